// ===== bench/fpec_assertions.sv
// fpec_assertions: port level checks for fpec_top
`timescale 1ns/1ps
`default_nettype none
module fpec_assertions
  import fpec_pkg::*;
#(
  parameter int WRITE_CYC = 4
)
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory port and config word
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ready,
  input wire logic        hard_fault,
  input wire logic [31:0] cfg_word0
);
  localparam int WMAX = WRITE_CYC + 1;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  property p_apb_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer late");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse)
    else $error("pready longer than one cycle");
  property p_slverr;
    pslverr |-> pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("pslverr without pready");
  property p_bad_write;
    $rose(mem_req) && mem_we
      && (mem_size != 2'h2 || mem_addr[1:0] != 2'h0)
      |=> hard_fault && mem_ready;
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("bad write not faulted");
  property p_fault_pair;
    hard_fault |-> mem_ready;
  endproperty
  a_fault_pair: assert property (p_fault_pair)
    else $error("fault without ready");
  property p_write_time;
    $rose(mem_req) && mem_we |-> ##[1:WMAX] mem_ready;
  endproperty
  a_write_time: assert property (p_write_time)
    else $error("word write too slow");
  property p_no_stray;
    mem_ready |-> $past(mem_req) ##1 !mem_ready;
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("stray or long mem_ready");
  property p_rst_vals;
    $fell(srst) |-> cfg_word0 == FPEC_ERASED_WORD && !pready
      && !mem_ready;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset values wrong");
  // config only moves right after reset
  property p_cfg_hold;
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3)
      && !$past(srst, 4) |-> $stable(cfg_word0);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed without reset");
endmodule : fpec_assertions
`default_nettype wire

// ===== bench/fpec_cpu_model.sv
// fpec_cpu_model: processor side of the memory port
`timescale 1ns/1ps
`default_nettype none
module fpec_cpu_model
(
  // clock
  input  wire logic        clk_sys,
  // request
  output var  logic        mem_req,
  output var  logic        mem_we,
  output var  logic        mem_ifetch,
  output var  logic [1:0]  mem_size,
  output var  logic [31:0] mem_addr,
  output var  logic [31:0] mem_wdata,
  // answer
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ready,
  input  wire logic        hard_fault
);
  initial
  begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_ifetch = 1'b0;
    mem_size = 2'h2;
    mem_addr = 32'h0;
    mem_wdata = 32'h0;
  end
  // core only, no debug host acting meanwhile
  task automatic access(input logic w, input logic [1:0] s,
    input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic f, output int n);
    mem_req <= 1'b1;
    mem_we <= w;
    mem_size <= s;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_sys);
    n = 1;
    while (mem_ready !== 1'b1)
    begin
      @(posedge clk_sys);
      n++;
    end
    q = mem_rdata;
    f = hard_fault;
    mem_req <= 1'b0;
    // released bus must not keep its last value
    mem_addr <= ~a;
    mem_wdata <= ~d;
    @(posedge clk_sys);
  endtask : access
endmodule : fpec_cpu_model
`default_nettype wire

// ===== bench/fpec_top_tb.sv
// fpec_top_tb: self-checking bench for fpec_top
`timescale 1ns/1ps
`default_nettype none
module fpec_top_tb;
  import fpec_pkg::*;
  localparam int WC = 4;
  localparam int PC = 8300;
  localparam int AC = 8400;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] cfg_word0, q, md;
  logic mem_req, mem_we, mem_ifetch, mem_ready, hard_fault, e, mf;
  logic [1:0] mem_size;
  int n_errors, checks_done, mn, cyc_cnt;

  fpec_top #(.WRITE_CYC(WC), .PAGE_CYC(PC), .ALL_CYC(AC))
  fpec_top_inst
  (
    .clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_ifetch(mem_ifetch), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .hard_fault(hard_fault), .cfg_word0(cfg_word0)
  );
  fpec_cpu_model fpec_cpu_model_inst
  (
    .clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_ifetch(mem_ifetch), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .hard_fault(hard_fault)
  );

  // --------
  // helpers
  // --------
  task automatic chk(input string w, input logic [31:0] x,
    input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask : apb
  task automatic mode(input fpec_mode_t m);
    apb(1'b1, FPEC_OFS_CONFIG, {30'h0, m});
  endtask : mode
  task automatic mem(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    fpec_cpu_model_inst.access(w, 2'h2, a, d, md, mf, mn);
  endtask : mem
  task automatic wait_idle(input int lim);
    int t0;
    t0 = cyc_cnt;
    q = 32'h0;
    while (q !== 32'h1 && cyc_cnt - t0 < lim + 100)
      apb(1'b0, FPEC_OFS_READY, 32'h0);
    chk("erase time", 32'h1, {31'h0, cyc_cnt - t0 <= lim + 20});
  endtask : wait_idle
  task automatic do_reset();
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // --------
  // scenarios
  // --------
  task automatic t_regs();
    apb(1'b0, FPEC_OFS_CONFIG, 32'h0);
    chk("config reset", 32'h0, q);
    apb(1'b0, FPEC_OFS_READY, 32'h0);
    chk("ready idle", 32'h1, q);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, FPEC_OFS_CONFIG, 32'(m));
      apb(1'b0, FPEC_OFS_CONFIG, 32'h0);
      chk("mode", 32'(m), q);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_prog();
    mode(FPEC_MODE_WRITE);
    mem(1'b1, 32'h10, 32'h0F0F_55AA);
    chk("write time", 32'h1, {31'h0, mn > WC && mn <= WC + 2});
    mem(1'b1, 32'h10, 32'hFF00_FF0F);
    mem(1'b0, 32'h10, 32'h0);
    chk("and merge", 32'h0F00_550A, md);
    mem(1'b1, 32'h1000, 32'h1234_5678);
    for (int i = 0; i < 3; i++)
    begin
      fpec_cpu_model_inst.access(1'b1, (i == 2) ? 2'h2 : 2'(i),
        32'h10 + 32'(i), 32'h0, md, mf, mn);
      chk("fault", 32'h1, {31'h0, mf});
    end
    mode(FPEC_MODE_READ);
    mem(1'b1, 32'h10, 32'h0);
    mode(FPEC_MODE_ERASE);
    mem(1'b1, 32'h10, 32'h0);
    mem(1'b0, 32'h10, 32'h0);
    chk("ignored write", 32'h0F00_550A, md);
    $display("test prog done");
  endtask : t_prog
  task automatic t_erase();
    mode(FPEC_MODE_WRITE);
    apb(1'b1, FPEC_OFS_ERPAGE, 32'h0);
    apb(1'b0, FPEC_OFS_READY, 32'h0);
    chk("erase refused", 32'h1, q);
    mode(FPEC_MODE_ERASE);
    apb(1'b1, FPEC_OFS_ERPAGE, 32'h1000);
    apb(1'b0, FPEC_OFS_READY, 32'h0);
    chk("busy", 32'h0, q);
    wait_idle(PC);
    mem(1'b0, 32'h1000, 32'h0);
    chk("page erased", FPEC_ERASED_WORD, md);
    mem(1'b0, 32'h10, 32'h0);
    chk("other page", 32'h0F00_550A, md);
    $display("test erase done");
  endtask : t_erase
  task automatic t_cfg();
    mode(FPEC_MODE_WRITE);
    mem(1'b1, FPEC_CFG_BASE, 32'hA5C3_0F96);
    chk("cfg time", 32'h1, {31'h0, mn <= WC + 2});
    chk("cfg early", FPEC_ERASED_WORD, cfg_word0);
    do_reset();
    repeat (4) @(posedge clk_sys);
    chk("cfg late", 32'hA5C3_0F96, cfg_word0);
    mode(FPEC_MODE_ERASE);
    apb(1'b1, FPEC_OFS_ERCFG, 32'h1);
    wait_idle(PC);
    mem(1'b0, FPEC_CFG_BASE, 32'h0);
    chk("cfg erased", FPEC_ERASED_WORD, md);
    mem(1'b0, 32'h10, 32'h0);
    chk("code kept", 32'h0F00_550A, md);
    mode(FPEC_MODE_WRITE);
    mem(1'b1, FPEC_CFG_BASE, 32'h0);
    mode(FPEC_MODE_ERASE);
    apb(1'b1, FPEC_OFS_ERALL, 32'h1);
    wait_idle(AC);
    mem(1'b0, 32'h10, 32'h0);
    chk("all code", FPEC_ERASED_WORD, md);
    mem(1'b0, FPEC_CFG_BASE, 32'h0);
    chk("all cfg", FPEC_ERASED_WORD, md);
    $display("test cfg done");
  endtask : t_cfg

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc_cnt <= cyc_cnt + 1;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'b1;
    do_reset();
    t_regs();
    t_prog();
    t_erase();
    t_cfg();
    print_verdict();
  end
  // erases dominate, about 10k cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule : fpec_top_tb
bind fpec_top fpec_assertions #(.WRITE_CYC(WRITE_CYC))
fpec_assertions_inst
(
  .clk_sys(clk_sys), .srst(srst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
  .mem_addr(mem_addr), .mem_ready(mem_ready),
  .hard_fault(hard_fault), .cfg_word0(cfg_word0)
);
`default_nettype wire

// ===== hw/fpec_array.sv
// fpec_array: word store with registered read and single write port
`timescale 1ns/1ps
`default_nettype none
module fpec_array
  import fpec_pkg::*;
#(
  parameter int AW = 8
)
(
  // clock
  input  wire logic          clk_sys,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output var  logic [31:0]   rdata_q
);

  logic [31:0] mem [0:(1<<AW)-1];

  // contents start erased; no reset on the array itself
  initial
  begin
    for (int i = 0; i < (1 << AW); i++)
    begin
      mem[i] = FPEC_ERASED_WORD;
    end
  end

  // plain always: the erased preset above writes mem as well
  always @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rdata_q <= mem[raddr];
  end

endmodule : fpec_array
`default_nettype wire

// ===== hw/fpec_pkg.sv
// fpec_pkg: constants for the flash program and erase controller
package fpec_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [11:0] FPEC_OFS_READY    = 12'h400;
  localparam logic [11:0] FPEC_OFS_CONFIG   = 12'h504;
  localparam logic [11:0] FPEC_OFS_ERPAGE   = 12'h508;
  localparam logic [11:0] FPEC_OFS_ERALL    = 12'h50C;
  localparam logic [11:0] FPEC_OFS_ERCFG    = 12'h514;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          FPEC_MODE_LSB     = 0;
  localparam int          FPEC_MODE_W       = 2;
  localparam int          FPEC_READY_BIT    = 0;
  localparam int          FPEC_CMD_BIT      = 0;
  localparam logic [1:0]  FPEC_MODE_RST     = 2'h0;

  // ----------------------------------------------------------------
  // memory geometry: 4 kB pages of 8 blocks, small model array
  // ----------------------------------------------------------------
  localparam int          FPEC_PAGE_BYTES   = 4096;
  localparam int          FPEC_PAGE_BLOCKS  = 8;
  localparam int          FPEC_PAGE_WORDS   = FPEC_PAGE_BYTES / 4;
  localparam int          FPEC_PAGES        = 2;
  localparam int          FPEC_CODE_AW      = 13;
  localparam int          FPEC_CFG_AW       = 6;
  localparam logic [31:0] FPEC_CFG_BASE     = 32'h1000_1000;
  localparam logic [31:0] FPEC_ERASED_WORD  = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // timing at 10 MHz (100 ns period)
  // ----------------------------------------------------------------
  localparam int          FPEC_CLK_HZ       = 10_000_000;
  localparam int          FPEC_T_WRITE_US   = 41;
  localparam int          FPEC_T_PAGE_MS    = 85;
  localparam int          FPEC_T_ALL_MS     = 169;
  localparam int          FPEC_WRITE_CYC    =
    FPEC_T_WRITE_US * (FPEC_CLK_HZ / 1_000_000);
  localparam int          FPEC_PAGE_CYC     =
    FPEC_T_PAGE_MS * (FPEC_CLK_HZ / 1000);
  localparam int          FPEC_ALL_CYC      =
    FPEC_T_ALL_MS * (FPEC_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // access modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FPEC_MODE_READ  = 2'b00,
    FPEC_MODE_WRITE = 2'b01,
    FPEC_MODE_ERASE = 2'b10
  } fpec_mode_t;

  typedef enum logic [2:0]
  {
    FPEC_ST_IDLE    = 3'b000,
    FPEC_ST_PROG    = 3'b001,
    FPEC_ST_ERPAGE  = 3'b010,
    FPEC_ST_ERCFG   = 3'b011,
    FPEC_ST_ERALL   = 3'b100,
    FPEC_ST_SWEEP   = 3'b101
  } fpec_state_t;

endpackage : fpec_pkg

// ===== hw/fpec_top.sv
// fpec_top: flash program/erase controller with APB registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1: software never enables write and erase together
// RL2: debug host halts processor before operations
// RL3: program whole words at aligned addresses
// RL4: software limits writes per word
// RL5: programming only clears bits (old AND new)
// RL6: partial updates write ones elsewhere
// RL7: byte or halfword writes raise hard fault
// RL8: word write bounded, bus stalled throughout
// RL9: page erase sets page to ones
// RL10: page erase stalls only flash fetches; code stalls every read while busy
// RL11: config area programmed alike, effective after reset
// RL12: software limits config writes before erase
// RL13: config word write bounded, bus stalled
// RL14: config erase sets area to ones
// RL15: erase-all clears flash and config only
// RL16: erase-all bounded, stalls only flash fetches; code stalls every read while busy
// RL17: pages of 4 kB, 8 blocks each
// RL18: mode field 0 read, 1 write, 2 erase
// RL19: ready flag low while busy
// RL20: page erase value is page start address
// RL21: disabled writes and erases are ignored
module fpec_top
  import fpec_pkg::*;
#(
  parameter int WRITE_CYC = FPEC_WRITE_CYC,
  parameter int PAGE_CYC  = FPEC_PAGE_CYC,
  parameter int ALL_CYC   = FPEC_ALL_CYC
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // apb register slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // processor memory port (code and config space)
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_ifetch,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output var  logic [31:0] mem_rdata,
  output var  logic        mem_ready,
  output var  logic        hard_fault,
  // config word seen by the rest of the chip since last reset
  output var  logic [31:0] cfg_word0
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_cfg(input logic [31:0] a);
    is_cfg = (a[31:12] == FPEC_CFG_BASE[31:12]);
  endfunction : is_cfg

  function automatic logic [31:0] cnt_load(input int n);
    cnt_load = (n < 1) ? 32'h0000_0001 : 32'(n);
  endfunction : cnt_load

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpec_state_t                 st_q, st_d;
  fpec_mode_t                  mode_q, mode_d;
  logic [31:0]                 cnt_q, cnt_d;
  logic [FPEC_CODE_AW-1:0]     sw_q, sw_d;
  logic [FPEC_CODE_AW-1:0]     sw_end_q, sw_end_d;
  logic                        sw_cfg_q, sw_cfg_d;
  logic                        sw_code_q, sw_code_d;
  logic [31:0]                 wa_q, wa_d;
  logic [31:0]                 wd_q, wd_d;
  logic                        wcfg_q, wcfg_d;
  logic                        pready_q, pready_d;
  logic [31:0]                 prdata_q, prdata_d;
  logic                        pslverr_q, pslverr_d;
  logic                        mrdy_q, mrdy_d;
  logic                        fault_q, fault_d;
  logic                        rd_pend_q, rd_pend_d;
  logic                        rd_cfg_q, rd_cfg_d;
  logic                        boot_q, boot_d;
  logic [31:0]                 cfgw_q, cfgw_d;

  // array ports
  logic                        code_we, cfg_we;
  logic [FPEC_CODE_AW-1:0]     code_wa, code_ra;
  logic [FPEC_CFG_AW-1:0]      cfg_wa, cfg_ra;
  logic [31:0]                 code_wd, cfg_wd, code_rd, cfg_rd;

  logic                        busy;
  logic                        apb_acc;
  logic                        apb_wr;
  logic                        mem_rd_ok;

  assign busy    = (st_q != FPEC_ST_IDLE);
  assign apb_acc = psel && penable && !pready_q;
  assign apb_wr  = psel && penable && pready_q && pwrite;

  // ----------------------------------------------------------------
  // arrays
  // ----------------------------------------------------------------
  fpec_array #(.AW(FPEC_CODE_AW)) u_code
  (
    .clk_sys (clk_sys),
    .we      (code_we),
    .waddr   (code_wa),
    .wdata   (code_wd),
    .raddr   (code_ra),
    .rdata_q (code_rd)
  );

  fpec_array #(.AW(FPEC_CFG_AW)) u_cfg
  (
    .clk_sys (clk_sys),
    .we      (cfg_we),
    .waddr   (cfg_wa),
    .wdata   (cfg_wd),
    .raddr   (cfg_ra),
    .rdata_q (cfg_rd)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d      = st_q;
    mode_d    = mode_q;
    cnt_d     = cnt_q;
    sw_d      = sw_q;
    sw_end_d  = sw_end_q;
    sw_cfg_d  = sw_cfg_q;
    sw_code_d = sw_code_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    wcfg_d    = wcfg_q;
    pready_d  = 1'b0;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    mrdy_d    = 1'b0;
    fault_d   = 1'b0;
    rd_pend_d = 1'b0;
    rd_cfg_d  = rd_cfg_q;
    boot_d    = 1'b0;
    cfgw_d    = cfgw_q;
    code_we   = 1'b0;
    cfg_we    = 1'b0;
    code_wa   = sw_q;
    cfg_wa    = sw_q[FPEC_CFG_AW-1:0];
    code_wd   = FPEC_ERASED_WORD;
    cfg_wd    = FPEC_ERASED_WORD;
    code_ra   = mem_addr[FPEC_CODE_AW+1:2];
    cfg_ra    = mem_addr[FPEC_CFG_AW+1:2];
    // reads of the array: every read stalls while an operation is busy
    mem_rd_ok = !busy || (!mem_ifetch && is_cfg(mem_addr) == 1'b0
                          && st_q == FPEC_ST_IDLE); // RL10 RL14 RL16

    // captured config value takes effect only from reset
    if (srst)
    begin
      boot_d  = 1'b1; // RL11
      cfg_ra  = '0;
    end
    if (boot_q)
    begin
      cfgw_d = cfg_rd; // RL11
    end

    // apb: answer after one wait state, writes land as pready is seen
    if (apb_acc || apb_wr)
    begin
      pready_d = apb_acc;
      prdata_d = 32'h0000_0000;
      case (paddr)
        FPEC_OFS_READY:
        begin
          prdata_d[FPEC_READY_BIT] = !busy; // RL19
        end
        FPEC_OFS_CONFIG:
        begin
          prdata_d[FPEC_MODE_W-1:0] = mode_q;
          if (apb_wr)
          begin
            mode_d = fpec_mode_t'(pwdata[FPEC_MODE_W-1:0]); // RL18
          end
        end
        FPEC_OFS_ERPAGE:
        begin
          if (apb_wr && !busy && mode_q == FPEC_MODE_ERASE) // RL21
          begin
            // page granularity: low bits of the value ignored
            sw_d      = {pwdata[FPEC_CODE_AW+1:12], 10'h000}; // RL17 RL20
            sw_end_d  = {pwdata[FPEC_CODE_AW+1:12], 10'h3FF};
            sw_code_d = 1'b1;
            sw_cfg_d  = 1'b0;
            cnt_d     = cnt_load(PAGE_CYC);
            st_d      = FPEC_ST_ERPAGE; // RL9
          end
        end
        FPEC_OFS_ERALL:
        begin
          if (apb_wr && pwdata[FPEC_CMD_BIT] && !busy
              && mode_q == FPEC_MODE_ERASE) // RL21
          begin
            // factory info area is not in this block at all
            sw_d      = '0;
            sw_end_d  = '1;
            sw_code_d = 1'b1;
            sw_cfg_d  = 1'b1; // RL15
            cnt_d     = cnt_load(ALL_CYC);
            st_d      = FPEC_ST_ERALL; // RL16
          end
        end
        FPEC_OFS_ERCFG:
        begin
          if (apb_wr && pwdata[FPEC_CMD_BIT] && !busy
              && mode_q == FPEC_MODE_ERASE) // RL21
          begin
            sw_d      = '0;
            sw_end_d  = FPEC_CODE_AW'((1 << FPEC_CFG_AW) - 1);
            sw_code_d = 1'b0;
            sw_cfg_d  = 1'b1;
            cnt_d     = cnt_load(PAGE_CYC);
            st_d      = FPEC_ST_ERCFG; // RL14
          end
        end
        default:
        begin
          pslverr_d = apb_acc;
        end
      endcase
    end

    // processor memory port
    if (mem_req && !mrdy_q && !rd_pend_q && !fault_q)
    begin
      if (mem_we)
      begin
        if (mem_size != 2'h2 || mem_addr[1:0] != 2'h0)
        begin
          fault_d = 1'b1; // RL7 RL3
          mrdy_d  = 1'b1;
        end
        else if (mode_q != FPEC_MODE_WRITE)
        begin
          mrdy_d = 1'b1; // RL21
        end
        else if (!busy)
        begin
          // latch, read old word, then program; bus held meanwhile
          wa_d      = mem_addr;
          wd_d      = mem_wdata;
          wcfg_d    = is_cfg(mem_addr);
          cnt_d     = cnt_load(WRITE_CYC);
          st_d      = FPEC_ST_PROG; // RL8 RL13
        end
      end
      else if (mem_rd_ok)
      begin
        rd_pend_d = 1'b1;
        rd_cfg_d  = is_cfg(mem_addr);
      end
    end
    if (rd_pend_q)
    begin
      mrdy_d = 1'b1;
    end

    // operations in progress
    case (st_q)
      FPEC_ST_IDLE:
      begin
      end
      FPEC_ST_PROG:
      begin
        code_ra = wa_q[FPEC_CODE_AW+1:2];
        cfg_ra  = wa_q[FPEC_CFG_AW+1:2];
        cnt_d   = cnt_q - 32'h0000_0001;
        if (cnt_q == 32'h0000_0001)
        begin
          // only clears bits: stored = old AND new
          code_wa = wa_q[FPEC_CODE_AW+1:2];
          cfg_wa  = wa_q[FPEC_CFG_AW+1:2];
          code_wd = code_rd & wd_q; // RL5
          cfg_wd  = cfg_rd & wd_q; // RL5 RL11
          code_we = !wcfg_q;
          cfg_we  = wcfg_q;
          mrdy_d  = 1'b1; // RL8
          st_d    = FPEC_ST_IDLE;
        end
      end
      FPEC_ST_ERPAGE, FPEC_ST_ERCFG, FPEC_ST_ERALL:
      begin
        // the timer runs first; sweep fits in the erase budget
        cnt_d = cnt_q - 32'h0000_0001;
        if (cnt_q <= 32'(1 << FPEC_CODE_AW) + 32'h0000_0001)
        begin
          st_d = FPEC_ST_SWEEP;
        end
      end
      FPEC_ST_SWEEP:
      begin
        code_we = sw_code_q; // RL9 RL15
        cfg_we  = sw_cfg_q && (sw_q < FPEC_CODE_AW'(1 << FPEC_CFG_AW));
        sw_d    = sw_q + FPEC_CODE_AW'(1);
        if (sw_q == sw_end_q)
        begin
          st_d = FPEC_ST_IDLE;
        end
      end
      default:
      begin
        st_d = FPEC_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q      <= FPEC_ST_IDLE;
      mode_q    <= fpec_mode_t'(FPEC_MODE_RST); // RL18
      cnt_q     <= 32'h0000_0000;
      sw_q      <= '0;
      sw_end_q  <= '0;
      sw_cfg_q  <= 1'b0;
      sw_code_q <= 1'b0;
      wa_q      <= 32'h0000_0000;
      wd_q      <= 32'h0000_0000;
      wcfg_q    <= 1'b0;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      mrdy_q    <= 1'b0;
      fault_q   <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_cfg_q  <= 1'b0;
      boot_q    <= 1'b1;
      cfgw_q    <= FPEC_ERASED_WORD;
    end
    else
    begin
      st_q      <= st_d;
      mode_q    <= mode_d;
      cnt_q     <= cnt_d;
      sw_q      <= sw_d;
      sw_end_q  <= sw_end_d;
      sw_cfg_q  <= sw_cfg_d;
      sw_code_q <= sw_code_d;
      wa_q      <= wa_d;
      wd_q      <= wd_d;
      wcfg_q    <= wcfg_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      mrdy_q    <= mrdy_d;
      fault_q   <= fault_d;
      rd_pend_q <= rd_pend_d;
      rd_cfg_q  <= rd_cfg_d;
      boot_q    <= boot_d;
      cfgw_q    <= cfgw_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata     = prdata_q;
    pready     = pready_q;
    pslverr    = pslverr_q;
    mem_ready  = mrdy_q;
    hard_fault = fault_q;
    cfg_word0  = cfgw_q;
    mem_rdata  = rd_cfg_q ? cfg_rd : code_rd;
  end

endmodule : fpec_top
`default_nettype wire
